// *** cdcp_pkg.sv ***
package cdcp_pkg;

    // data path and array geometry
    localparam int DATA_W    = 9;
    localparam int BANKS     = 8;
    localparam int ADDR_W    = 5;
    localparam int ROW_W     = 14;
    localparam int DLY_DEPTH = 18;

    // command pin encodings
    localparam logic [2:0] CMD_IDLE      = 3'h0;
    localparam logic [2:0] CMD_READ      = 3'h1;
    localparam logic [2:0] CMD_WRITE     = 3'h2;
    localparam logic [2:0] CMD_REFRESH   = 3'h3;
    localparam logic [2:0] CMD_MODE_LOAD = 3'h4;

    // mode word fields carried on the address pins
    localparam int CFG_LSB               = 0;
    localparam int BURST_LENGTH_BIT_LOW  = 3;
    localparam int BURST_LENGTH_BIT_HIGH = 4;

    // reset values of the mode word
    localparam logic [2:0] CFG_RESET = 3'h1;
    localparam logic [1:0] BL_RESET  = 2'h0;

    // burst length codes
    localparam logic [1:0] BL_CODE_2 = 2'h0;
    localparam logic [1:0] BL_CODE_4 = 2'h1;
    localparam logic [1:0] BL_CODE_8 = 2'h2;

    // latency and row cycle per configuration, in command cycles
    localparam logic [3:0] LAT_CFG1 = 4'h4;
    localparam logic [3:0] LAT_CFG2 = 4'h6;
    localparam logic [3:0] LAT_CFG3 = 4'h8;
    localparam logic [3:0] LAT_CFG4 = 4'h3;
    localparam logic [3:0] LAT_CFG5 = 4'h5;

    // mode loads seen before the one that resets the logic
    localparam logic [1:0] ML_RUN_RESET = 2'h2;

    // write engine states, gray from idle through armed to data; data back to idle flips both bits
    typedef enum logic [1:0] {
        WR_IDLE  = 2'b00,
        WR_ARMED = 2'b01,
        WR_DATA  = 2'b11
    } cdcp_wr_state_t;

    // one command as it stands on the pins
    typedef struct packed {
        logic [2:0]        cmd;
        logic [2:0]        bank;
        logic [ADDR_W-1:0] addr;
    } cdcp_cmd_t;

    // one entry of the latency delay line
    typedef struct packed {
        logic       vld;
        logic       wr;
        logic [2:0] bank;
        logic [2:0] col;
    } cdcp_slot_t;

endpackage

// *** cdcp_dram_cmd_protocol.sv ***
`timescale 1ns/1ns
module cdcp_dram_cmd_protocol (
    // clock and reset
    input  wire logic                          clk_sys_i,
    input  wire logic                          resetn_i,
    // command port from the controller
    input  wire logic [2:0]                    cmd_i,
    input  wire logic [2:0]                    bank_i,
    input  wire logic [cdcp_pkg::ADDR_W-1:0]   addr_i,
    // write side pins
    input  wire logic                          write_data_clock_i,
    input  wire logic [cdcp_pkg::DATA_W-1:0]   wdata_i,
    input  wire logic                          write_mask_i,
    input  wire logic                          clock_fault_i,
    // read side pins
    output logic                               read_output_clock_o,
    output logic [cdcp_pkg::DATA_W-1:0]        dq_o,
    output logic                               dq_oe_o,
    output logic                               read_valid_flag_o,
    // status
    output logic [cdcp_pkg::BANKS-1:0]         bank_busy_o,
    output logic [cdcp_pkg::ROW_W-1:0]         refresh_row_o
);

    // latency per configuration code
    function automatic logic [3:0] lat_cycles(input logic [2:0] cfg);
        logic [3:0] r;
        r = cdcp_pkg::LAT_CFG1;
        unique case (cfg)
            3'h2:    r = cdcp_pkg::LAT_CFG2;
            3'h3:    r = cdcp_pkg::LAT_CFG3;
            3'h4:    r = cdcp_pkg::LAT_CFG4;
            3'h5:    r = cdcp_pkg::LAT_CFG5;
            default: r = cdcp_pkg::LAT_CFG1;
        endcase
        return r;
    endfunction

    // words per burst from the two mode bits
    function automatic logic [3:0] bl_words(input logic [1:0] code);
        logic [3:0] w;
        w = 4'h2;
        if (code == cdcp_pkg::BL_CODE_4) begin
            w = 4'h4;
        end else if (code == cdcp_pkg::BL_CODE_8) begin
            w = 4'h8;
        end
        return w;
    endfunction

    // array word of a bank, column and beat, wrapping in the column
    function automatic logic [5:0] word_idx(input logic [2:0] b, input logic [2:0] c,
                                            input logic [2:0] beat);
        logic [2:0] s;
        s = 3'(c + beat);
        return {b, s};
    endfunction

    // synchronisers for pins from the controller's clock domain
    logic [11:0]                    sync1_ff;
    logic [11:0]                    sync2_ff;
    logic                           wclk_d_ff;
    // mode, init and flags
    logic [2:0]                     cfg_ff;
    logic [1:0]                     bl_ff;
    logic [1:0]                     ml_run_ff;
    logic                           stuck_ff;
    logic                           rclk_ff;
    // latency delay line and per-bank state
    cdcp_pkg::cdcp_slot_t           dly_ff [cdcp_pkg::DLY_DEPTH];
    logic [4:0]                     busy_cnt_ff [cdcp_pkg::BANKS];
    logic [cdcp_pkg::ROW_W-1:0]     row_ctr_ff [cdcp_pkg::BANKS];
    logic [cdcp_pkg::ROW_W-1:0]     ref_row_ff;
    logic [cdcp_pkg::BANKS-1:0]     busy_o_ff;
    // read engine
    logic [3:0]                     rd_left_ff;
    logic [2:0]                     rd_beat_ff;
    logic [2:0]                     rd_bank_ff;
    logic [2:0]                     rd_col_ff;
    logic [cdcp_pkg::DATA_W-1:0]    dq_ff;
    logic                           oe_ff;
    logic                           valid_ff;
    // write engine
    cdcp_pkg::cdcp_wr_state_t       wr_st_ff;
    logic [3:0]                     wr_left_ff;
    logic [2:0]                     wr_beat_ff;
    logic [2:0]                     wr_bank_ff;
    logic [2:0]                     wr_col_ff;
    // storage
    logic [cdcp_pkg::DATA_W-1:0]    mem [64];

    // pin view: write pins after synchronisation, command pins taken direct
    cdcp_pkg::cdcp_cmd_t            cmd_w;
    wire                            wclk_s = sync2_ff[11];
    wire                            wmask_s = sync2_ff[10];
    wire [cdcp_pkg::DATA_W-1:0]     wdata_s = sync2_ff[9:1];
    wire                            fault_s = sync2_ff[0];
    wire                            wclk_rise = wclk_s & ~wclk_d_ff;
    wire                            wclk_edge = wclk_s ^ wclk_d_ff;
    assign cmd_w = '{cmd: cmd_i, bank: bank_i, addr: addr_i};

    // command decode and bank gating
    wire [3:0]  lat = lat_cycles(cfg_ff);
    wire [3:0]  blw = bl_words(bl_ff);
    wire [4:0]  lat2 = {lat, 1'b0};
    wire        bank_free = (busy_cnt_ff[cmd_w.bank] == 5'h00);
    wire        is_read = (cmd_w.cmd == cdcp_pkg::CMD_READ);
    wire        is_ml = (cmd_w.cmd == cdcp_pkg::CMD_MODE_LOAD);
    wire        acc_rd = is_read & bank_free;
    wire        acc_wr = (cmd_w.cmd == cdcp_pkg::CMD_WRITE) & bank_free;
    wire        acc_ref = (cmd_w.cmd == cdcp_pkg::CMD_REFRESH) & bank_free;
    wire        soft_rst = is_ml & (ml_run_ff >= cdcp_pkg::ML_RUN_RESET);
    wire        clr = ~resetn_i | soft_rst;
    wire [4:0]  busy_load = 5'(lat2 - 5'h01);

    // delay line taps: read data, early valid, write arm
    cdcp_pkg::cdcp_slot_t           rd_tap;
    cdcp_pkg::cdcp_slot_t           pre_tap;
    cdcp_pkg::cdcp_slot_t           wr_tap;
    assign rd_tap = dly_ff[5'(lat2 - 5'h01)];
    assign pre_tap = dly_ff[5'(lat2 - 5'h02)];
    assign wr_tap = dly_ff[5'(lat2 + 5'h01)];
    wire        rd_start = rd_tap.vld & ~rd_tap.wr;
    wire        rd_pre = pre_tap.vld & ~pre_tap.wr;
    wire        wr_arm = wr_tap.vld & wr_tap.wr;

    // read data selection
    wire [2:0]  rd_beat_sel = rd_start ? 3'h0 : rd_beat_ff;
    wire [5:0]  rd_addr = rd_start ? word_idx(rd_tap.bank, rd_tap.col, 3'h0)
                                   : word_idx(rd_bank_ff, rd_col_ff, rd_beat_ff);
    wire        rd_more = rd_start | (rd_left_ff != 4'h0);
    wire        nxt_valid = stuck_ff | rd_pre | rd_start | (rd_left_ff > 4'h1);

    // write capture
    wire        wr_take = ((wr_st_ff == cdcp_pkg::WR_ARMED) & wclk_rise)
                        | ((wr_st_ff == cdcp_pkg::WR_DATA) & wclk_edge);
    wire        wr_store = wr_take & ~wmask_s;
    wire [5:0]  wr_addr = word_idx(wr_bank_ff, wr_col_ff, wr_beat_ff);

    // two-flop synchronisers
    always_ff @(posedge clk_sys_i) begin
        sync1_ff <= {write_data_clock_i, write_mask_i, wdata_i, clock_fault_i};
        sync2_ff <= sync1_ff;
        wclk_d_ff <= wclk_s;
    end

    // free running read output clock
    always_ff @(posedge clk_sys_i) begin
        rclk_ff <= resetn_i ? ~rclk_ff : 1'b0;
    end

    // mode word and run of consecutive mode loads
    always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
            cfg_ff <= cdcp_pkg::CFG_RESET;
            bl_ff <= cdcp_pkg::BL_RESET;
            ml_run_ff <= 2'h0;
        end else begin
            ml_run_ff <= is_ml ? ((ml_run_ff == 2'h3) ? 2'h3 : ml_run_ff + 2'h1) : 2'h0;
            if (is_ml) begin
                cfg_ff <= cmd_w.addr[cdcp_pkg::CFG_LSB +: 3];
                bl_ff <= {cmd_w.addr[cdcp_pkg::BURST_LENGTH_BIT_HIGH],
                          cmd_w.addr[cdcp_pkg::BURST_LENGTH_BIT_LOW]};
            end
        end
    end

    // latency delay line, shifted every clock
    always_ff @(posedge clk_sys_i) begin
        for (int i = cdcp_pkg::DLY_DEPTH - 1; i > 0; i--) begin
            dly_ff[i] <= clr ? '0 : dly_ff[i-1];
        end
        dly_ff[0] <= clr ? '0 : cdcp_pkg::cdcp_slot_t'{vld: acc_rd | acc_wr, wr: acc_wr,
                                                      bank: cmd_w.bank, col: cmd_w.addr[2:0]};
    end

    // per-bank row cycle counters and refresh rows
    always_ff @(posedge clk_sys_i) begin
        for (int b = 0; b < cdcp_pkg::BANKS; b++) begin
            if (clr) begin
                busy_cnt_ff[b] <= 5'h00;
                row_ctr_ff[b] <= '0;
            end else if ((acc_rd | acc_wr | acc_ref) && cmd_w.bank == 3'(b)) begin
                busy_cnt_ff[b] <= busy_load;
                if (acc_ref) begin
                    row_ctr_ff[b] <= row_ctr_ff[b] + cdcp_pkg::ROW_W'(1);
                end
            end else if (busy_cnt_ff[b] != 5'h00) begin
                busy_cnt_ff[b] <= busy_cnt_ff[b] - 5'h01;
            end
            busy_o_ff[b] <= ~clr & ((acc_rd | acc_wr | acc_ref) && cmd_w.bank == 3'(b)
                                    || busy_cnt_ff[b] > 5'h01);
        end
    end

    // row taken by the latest refresh, address pins ignored
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            ref_row_ff <= '0;
        end else if (acc_ref) begin
            ref_row_ff <= row_ctr_ff[cmd_w.bank];
        end
    end

    // read burst engine
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            rd_left_ff <= 4'h0;
            rd_beat_ff <= 3'h0;
            rd_bank_ff <= 3'h0;
            rd_col_ff <= 3'h0;
            dq_ff <= '0;
            oe_ff <= 1'b0;
        end else begin
            if (rd_start) begin
                rd_bank_ff <= rd_tap.bank;
                rd_col_ff <= rd_tap.col;
            end
            rd_left_ff <= rd_start ? 4'(blw - 4'h1) : (rd_more ? rd_left_ff - 4'h1 : 4'h0);
            rd_beat_ff <= rd_more ? 3'(rd_beat_sel + 3'h1) : 3'h0;
            dq_ff <= rd_more ? mem[rd_addr] : '0;
            oe_ff <= rd_more;
        end
    end

    // valid flag, with stuck state after a disturbed burst
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            valid_ff <= 1'b0;
            stuck_ff <= 1'b0;
        end else begin
            valid_ff <= nxt_valid;
            stuck_ff <= (fault_s & (oe_ff | valid_ff)) | (stuck_ff & ~is_read);
        end
    end

    // write engine: arm after write latency, then take burst words
    always_ff @(posedge clk_sys_i) begin
        if (clr) begin
            wr_st_ff <= cdcp_pkg::WR_IDLE;
            wr_left_ff <= 4'h0;
            wr_beat_ff <= 3'h0;
            wr_bank_ff <= 3'h0;
            wr_col_ff <= 3'h0;
        end else if (wr_arm) begin
            wr_st_ff <= cdcp_pkg::WR_ARMED;
            wr_left_ff <= blw;
            wr_beat_ff <= 3'h0;
            wr_bank_ff <= wr_tap.bank;
            wr_col_ff <= wr_tap.col;
        end else if (wr_take) begin
            wr_st_ff <= (wr_left_ff == 4'h1) ? cdcp_pkg::WR_IDLE : cdcp_pkg::WR_DATA;
            wr_left_ff <= wr_left_ff - 4'h1;
            wr_beat_ff <= wr_beat_ff + 3'h1;
        end
    end

    // storage array write port
    always_ff @(posedge clk_sys_i) begin
        if (wr_store) begin
            mem[wr_addr] <= wdata_s;
        end
    end

    // outputs straight from flops
    assign read_output_clock_o = rclk_ff;
    assign dq_o = dq_ff;
    assign dq_oe_o = oe_ff;
    assign read_valid_flag_o = valid_ff;
    assign bank_busy_o = busy_o_ff;
    assign refresh_row_o = ref_row_ff;

endmodule

// *** cdcp_asserts.sv ***
`timescale 1ns/1ns
module cdcp_asserts (
    // clock, reset and command pins
    input wire logic       clk_sys_i,
    input wire logic       resetn_i,
    input wire logic [2:0] cmd_i,
    input wire logic [2:0] bank_i,
    // read side and status
    input wire logic       read_output_clock_o,
    input wire logic [8:0] dq_o,
    input wire logic       dq_oe_o,
    input wire logic       read_valid_flag_o,
    input wire logic [7:0] bank_busy_o
);
    // command decode and held-valid state
    wire rd_c  = cmd_i == cdcp_pkg::CMD_READ;
    wire acc   = rd_c || cmd_i == cdcp_pkg::CMD_WRITE || cmd_i == cdcp_pkg::CMD_REFRESH;
    wire vhold = read_valid_flag_o && !dq_oe_o;
    wire idle  = cmd_i == cdcp_pkg::CMD_IDLE;

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);

    chk_valid_lead: assert property ($rose(dq_oe_o) |-> $past(read_valid_flag_o))
        else $error("read data began without valid one edge ahead");
    chk_valid_last: assert property ($fell(read_valid_flag_o) && $past(dq_oe_o)
        |-> dq_oe_o ##1 !dq_oe_o) else $error("valid did not drop on the final word");
    chk_oe_release: assert property (dq_oe_o && !read_valid_flag_o |=> !dq_oe_o)
        else $error("data lines still driven after the burst");
    chk_dq_quiet: assert property (!dq_oe_o |-> dq_o == 9'h000)
        else $error("read data not cleared while released");
    chk_rclk_free: assert property ($past(resetn_i)
        |-> read_output_clock_o != $past(read_output_clock_o))
        else $error("read output clock stopped");
    chk_busy_take: assert property (acc && !bank_busy_o[bank_i]
        |=> bank_busy_o[$past(bank_i)]) else $error("accepted bank not marked busy");
    chk_busy_span: assert property ($rose(bank_busy_o[0])
        |-> bank_busy_o[0] [*5] ##[1:11] !bank_busy_o[0])
        else $error("bank busy span out of range");
    chk_stuck_hold: assert property (vhold && $past(vhold) && idle && !$past(rd_c)
        |=> read_valid_flag_o) else $error("held valid cleared without a read");
    chk_stuck_clear: assert property (rd_c && vhold && $past(vhold)
        |-> ##[1:2] !read_valid_flag_o) else $error("read did not clear held valid");

    // main scenarios reached
    cov_read: cover property ($rose(dq_oe_o));
    cov_stream: cover property (dq_oe_o [*4]);
    cov_stuck: cover property (vhold && $past(vhold));
endmodule

bind cdcp_dram_cmd_protocol cdcp_asserts i_cdcp_asserts (.clk_sys_i, .resetn_i, .cmd_i,
    .bank_i, .read_output_clock_o, .dq_o, .dq_oe_o, .read_valid_flag_o, .bank_busy_o);

// *** cdcp_ctrl_model.sv ***
`timescale 1ns/1ns
module cdcp_ctrl_model (
    // clock
    input  wire logic  clk_sys_i,
    // command pins
    output logic [2:0] cmd_o,
    output logic [2:0] bank_o,
    output logic [4:0] addr_o,
    // write pins
    output logic       wclk_o,
    output logic [8:0] wdata_o,
    output logic       wmask_o
);
    // idle pins from time zero; clock period never changes, no loop reset due
    initial begin
        cmd_o = cdcp_pkg::CMD_IDLE;
        bank_o = 3'h0;
        addr_o = 5'h00;
        wclk_o = 1'b0;
        wdata_o = 9'h1AA;
        wmask_o = 1'b1;
    end
    // one command slot then idle, so commands sit two edges apart
    task automatic send(input logic [2:0] c, b, input logic [4:0] a);
        @(negedge clk_sys_i);
        cmd_o = c;
        bank_o = b;
        addr_o = a;
        @(negedge clk_sys_i);
        cmd_o = cdcp_pkg::CMD_IDLE;
    endtask
    // three adjacent mode loads, dummies with address low
    task automatic mode_init(input logic [4:0] a);
        @(negedge clk_sys_i);
        cmd_o = cdcp_pkg::CMD_MODE_LOAD;
        addr_o = 5'h00;
        repeat (2) @(negedge clk_sys_i);
        addr_o = a;
        @(negedge clk_sys_i);
        cmd_o = cdcp_pkg::CMD_IDLE;
    endtask
    // write command, then a framed burst; write clock still outside it
    task automatic write(input logic [2:0] b, c, input int lat, n,
                         input logic [8:0] d [4], input logic [3:0] m);
        send(cdcp_pkg::CMD_WRITE, b, {2'h0, c});
        repeat (2 * lat + 4) @(negedge clk_sys_i);
        for (int k = 0; k < n; k++) begin
            wdata_o = d[k];
            wmask_o = m[k];
            #40 wclk_o = ~wclk_o;
            #40;
        end
        wdata_o = ~d[n-1];
        wmask_o = ~m[n-1];
    endtask
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
    // pins and bookkeeping
    logic        clk_sys_i, resetn_i, fault, wclk, wmask, rclk, oe, vld;
    logic [2:0]  cmd, bank;
    logic [4:0]  addr;
    logic [8:0]  wdata, dq;
    logic [7:0]  busy;
    logic [13:0] row;
    logic [8:0]  exp [8];
    int          fail_count = 0;
    int          tests_run = 0;

    cdcp_dram_cmd_protocol i_cdcp_dram_cmd_protocol (.clk_sys_i, .resetn_i, .cmd_i(cmd),
        .bank_i(bank), .addr_i(addr), .write_data_clock_i(wclk), .wdata_i(wdata),
        .write_mask_i(wmask), .clock_fault_i(fault), .read_output_clock_o(rclk), .dq_o(dq),
        .dq_oe_o(oe), .read_valid_flag_o(vld), .bank_busy_o(busy), .refresh_row_o(row));
    cdcp_ctrl_model i_cdcp_ctrl_model (.clk_sys_i, .cmd_o(cmd), .bank_o(bank),
        .addr_o(addr), .wclk_o(wclk), .wdata_o(wdata), .wmask_o(wmask));

    // 100 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    task automatic nx(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    task automatic chk(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic conclude;
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // refresh with address high, check row and busy
    task automatic rf(input logic [2:0] b, input logic [13:0] r);
        i_cdcp_ctrl_model.send(cdcp_pkg::CMD_REFRESH, b, 5'h1F);
        nx(1);
        chk(row === r && busy[b] === 1'b1, "refresh row or busy");
    endtask
    // one or two reads, judge lead, words and release
    task automatic rd(input logic [2:0] b0, c0, b1, c1, input logic two, input int n, lat);
        int k;
        k = 0;
        i_cdcp_ctrl_model.send(cdcp_pkg::CMD_READ, b0, {2'h0, c0});
        if (two) begin
            i_cdcp_ctrl_model.send(cdcp_pkg::CMD_READ, b1, {2'h0, c1});
            k = 2;
        end
        while (vld !== 1'b1 && k < 40) begin
            nx(1);
            k++;
        end
        chk(k == 2 * lat - 1, "valid lead time");
        nx(1);
        for (int i = 0; i < n; i++) begin
            chk(oe === 1'b1 && dq === exp[i], "read word");
            chk(vld === (i != n - 1), "valid beside data");
            nx(1);
        end
        chk(oe === 1'b0 && dq === 9'h000, "bus not released");
    endtask
    task automatic t_reset;
        chk(rclk === 1'b0 && oe === 1'b0 && vld === 1'b0 && busy === 8'h00, "reset");
        resetn_i = 1'b1;
        nx(1);
        chk(rclk === 1'b1, "read clock start");
        nx(1);
        chk(rclk === 1'b0, "read clock toggle");
    endtask
    // power-up idles, mode loads (latency 3, burst 4), a refresh per bank, bank 0 also while busy and again later
    task automatic t_init;
        nx(20000);
        i_cdcp_ctrl_model.mode_init(5'h0C);
        nx(16);
        rf(3'h0, 14'h0000);
        i_cdcp_ctrl_model.send(cdcp_pkg::CMD_REFRESH, 3'h0, 5'h00);
        for (int b = 1; b < 8; b++)
            rf(3'(b), 14'h0000);
        nx(1024);
        rf(3'h0, 14'h0001);
    endtask
    // wrapped burst, then a masked overwrite
    task automatic t_write_read;
        i_cdcp_ctrl_model.write(3'h2, 3'h6, 3, 4, '{9'h0A5, 9'h0B5, 9'h0C5, 9'h0D5}, 4'h0);
        i_cdcp_ctrl_model.write(3'h2, 3'h6, 3, 4, '{9'h111, 9'h122, 9'h133, 9'h144}, 4'h2);
        nx(4);
        exp = '{9'h111, 9'h0B5, 9'h133, 9'h144, 9'h000, 9'h000, 9'h000, 9'h000};
        rd(3'h2, 3'h6, 3'h0, 3'h0, 1'b0, 4, 3);
    endtask
    // burst 2, back-to-back reads from two banks
    task automatic t_stream;
        i_cdcp_ctrl_model.send(cdcp_pkg::CMD_MODE_LOAD, 3'h0, 5'h04);
        i_cdcp_ctrl_model.write(3'h3, 3'h0, 3, 2, '{9'h055, 9'h0AA, 9'h000, 9'h000}, 4'h0);
        nx(4);
        exp = '{9'h111, 9'h0B5, 9'h055, 9'h0AA, 9'h000, 9'h000, 9'h000, 9'h000};
        rd(3'h2, 3'h6, 3'h3, 3'h0, 1'b1, 4, 3);
    endtask
    // disturbed burst leaves valid high until a read
    task automatic t_stuck;
        i_cdcp_ctrl_model.send(cdcp_pkg::CMD_READ, 3'h3, 5'h00);
        fault = 1'b1;
        nx(12);
        fault = 1'b0;
        nx(8);
        chk(vld === 1'b1 && oe === 1'b0, "valid not held");
        i_cdcp_ctrl_model.send(cdcp_pkg::CMD_READ, 3'h3, 5'h00);
        nx(1);
        chk(vld === 1'b0, "held valid not cleared");
        nx(12);
    endtask
    // repeated mode loads clear the per-bank refresh rows
    task automatic t_soft;
        i_cdcp_ctrl_model.mode_init(5'h0C);
        nx(2);
        rf(3'h0, 14'h0000);
    endtask
    // main sequence
    initial begin
        resetn_i = 1'b0;
        fault = 1'b0;
        nx(16);
        t_reset;
        t_init;
        t_write_read;
        t_stream;
        t_stuck;
        t_soft;
        conclude;
    end
    // watchdog, about twice the expected run
    initial begin
        #450000;
        fail_count++;
        conclude;
    end
endmodule
